/* logic/aoc_pkg.sv */
// Constants for the converter output configuration register bank.
//---------------------------------------------------------------------
//---------------------------------------------------------------------
package aoc_pkg;

   // Register addresses.
   localparam logic [7:0] ADDR_FMT   = 8'h14;
   localparam logic [7:0] ADDR_TERM  = 8'h15;
   localparam logic [7:0] ADDR_PHASE = 8'h16;
   localparam logic [7:0] ADDR_PLO   = 8'h19;
   localparam logic [7:0] ADDR_PHI   = 8'h1A;

   // Reset values.
   localparam logic [7:0] RST_FMT   = 8'h00;
   localparam logic [7:0] RST_TERM  = 8'h00;
   localparam logic [7:0] RST_PHASE = 8'h03;
   localparam logic [7:0] RST_PAT   = 8'h00;

   // Implemented-bit masks; every other bit is unused.
   localparam logic [7:0] MASK_FMT   = 8'h47;
   localparam logic [7:0] MASK_TERM  = 8'h30;
   localparam logic [7:0] MASK_PHASE = 8'h0F;
   localparam logic [7:0] MASK_PAT   = 8'hFF;

   // Field positions.
   localparam int FMT_LP_BIT  = 6;
   localparam int FMT_INV_BIT = 2;
   localparam int FMT_ENC_LSB = 0;
   localparam int TERM_LSB    = 4;
   localparam int PHASE_LSB   = 0;

   // Sample encodings.
   localparam logic [1:0] ENC_OFFSET = 2'h0;
   localparam logic [1:0] ENC_TWOS   = 2'h1;

   // Phase codes 0..10 map one to one; 11 and above all mean 660 degrees.
   localparam logic [3:0] PHASE_CLAMP = 4'hB;
   localparam int         PHASE_STEP_DEG = 60;

   // Test output selection codes.
   localparam logic [3:0] TEST_OFF  = 4'h0;
   localparam logic [3:0] TEST_USER = 4'h8;

endpackage

/* logic/aoc_output_config_regs.sv */
// Output configuration registers and the output word selector they steer.
`timescale 1ns/10ps
module aoc_output_config_regs
#(
   parameter int SMP_W = 10,
   parameter int PAT_W = 16
)
(
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic             wr_en,
   input  wire logic             rd_en,
   input  wire logic [7:0]       reg_addr,
   input  wire logic [7:0]       wr_data,
   output logic      [7:0]       rd_data_q,
   input  wire logic [3:0]       test_mode,
   input  wire logic [PAT_W-1:0] test_gen_data,
   input  wire logic [SMP_W-1:0] conv_data,
   output logic      [PAT_W-1:0] data_out_q,
   output logic                  lvds_low_power,
   output logic      [1:0]       term_sel,
   output logic      [3:0]       clk_phase_sel,
   output logic      [PAT_W-1:0] user_pattern
);
   import aoc_pkg::*;

   //------------------------------------------------------------------
   // Register storage
   //------------------------------------------------------------------
   logic [7:0] fmt_q;
   logic [7:0] term_q;
   logic [7:0] phase_q;
   logic [7:0] plo_q;
   logic [7:0] phi_q;

   // Positions of each register in the one-hot select vector.
   localparam int SEL_FMT   = 0;
   localparam int SEL_TERM  = 1;
   localparam int SEL_PHASE = 2;
   localparam int SEL_PLO   = 3;
   localparam int SEL_PHI   = 4;
   localparam int SEL_N     = 5;

   // One-hot address decode, shared by the write strobes and the read mux
   // so that both always agree on which register an address reaches.
   function automatic logic [SEL_N-1:0] reg_select(input logic [7:0] addr);
      logic [SEL_N-1:0] sel;
      sel            = '0;
      sel[SEL_FMT]   = (addr == ADDR_FMT);
      sel[SEL_TERM]  = (addr == ADDR_TERM);
      sel[SEL_PHASE] = (addr == ADDR_PHASE);
      sel[SEL_PLO]   = (addr == ADDR_PLO);
      sel[SEL_PHI]   = (addr == ADDR_PHI);
      return sel;
   endfunction

   // Decoded select and a flag that is set for addresses that hit a register.
   logic [SEL_N-1:0] reg_sel;
   logic             addr_mapped;
   assign reg_sel     = reg_select(reg_addr);
   assign addr_mapped = |reg_sel;

   // Address decode of the write strobes.
   wire wr_fmt   = wr_en && reg_sel[SEL_FMT];
   wire wr_term  = wr_en && reg_sel[SEL_TERM];
   wire wr_phase = wr_en && reg_sel[SEL_PHASE];
   wire wr_plo   = wr_en && reg_sel[SEL_PLO];
   wire wr_phi   = wr_en && reg_sel[SEL_PHI];

   // Masked write keeps unused bits at zero.
   // mask unused bits
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fmt_q   <= RST_FMT;
         term_q  <= RST_TERM;
         phase_q <= RST_PHASE;
         plo_q   <= RST_PAT;
         phi_q   <= RST_PAT;
      end
      else
      begin
         if (wr_fmt)   fmt_q   <= wr_data & MASK_FMT;
         if (wr_term)  term_q  <= wr_data & MASK_TERM;
         if (wr_phase) phase_q <= wr_data & MASK_PHASE;
         if (wr_plo)   plo_q   <= wr_data & MASK_PAT;
         if (wr_phi)   phi_q   <= wr_data & MASK_PAT;
      end
   end

   // Read mux; unmapped addresses return zero.
   // unmapped reads zero
   logic [7:0] rd_mux;
   assign rd_mux = reg_sel[SEL_FMT]   ? fmt_q   :
                   reg_sel[SEL_TERM]  ? term_q  :
                   reg_sel[SEL_PHASE] ? phase_q :
                   reg_sel[SEL_PLO]   ? plo_q   :
                   reg_sel[SEL_PHI]   ? phi_q   : 8'h00;

   // Read data is captured on a read strobe and held until the next.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         rd_data_q <= 8'h00;
      else if (rd_en)
         rd_data_q <= rd_mux;
   end

   //------------------------------------------------------------------
   // Configuration fields
   //------------------------------------------------------------------
   // standard and invert
   logic       out_inv;
   assign lvds_low_power = fmt_q[FMT_LP_BIT];
   assign out_inv        = fmt_q[FMT_INV_BIT];

   logic [1:0] enc_sel;
   assign enc_sel = fmt_q[FMT_ENC_LSB +: 2];

   assign term_sel = term_q[TERM_LSB +: 2];

   logic [3:0] phase_code;
   assign phase_code    = phase_q[PHASE_LSB +: 4];
   assign clk_phase_sel = (phase_code > PHASE_CLAMP) ? PHASE_CLAMP : phase_code;

   assign user_pattern = {phi_q, plo_q};

   //------------------------------------------------------------------
   // Output word selection
   //------------------------------------------------------------------
   // Conversion word, MSB flipped for twos complement; other codes stay
   // offset binary so an undefined code never corrupts the data.
   localparam logic [PAT_W-1:0] MSB_MASK = PAT_W'(1) << (SMP_W - 1);
   logic [PAT_W-1:0] conv_word;
   logic [PAT_W-1:0] fmt_word;
   logic [PAT_W-1:0] sel_word;
   assign conv_word = PAT_W'(conv_data);
   assign fmt_word  = (enc_sel == ENC_TWOS) ? (conv_word ^ MSB_MASK) : conv_word;

   assign sel_word = (test_mode == TEST_OFF)  ? fmt_word     :
                     (test_mode == TEST_USER) ? user_pattern : test_gen_data;

   // The phase select goes only to the clock divider; capture here never
   // reads it, so a phase change cannot shift or drop a sample.
   // capture ignores phase
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         data_out_q <= '0;
      else
         data_out_q <= out_inv ? ~sel_word : sel_word;
   end

   //------------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------------
   sequence s_fmt_wr;
      wr_fmt;
   endsequence

   sequence s_term_wr;
      wr_term;
   endsequence

   sequence s_plain_path;
      (test_mode == TEST_OFF) && !out_inv;
   endsequence

   chk_lp_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_fmt_wr |=> lvds_low_power == $past(wr_data[FMT_LP_BIT]))
      else $error("low power select does not follow write");

   chk_invert_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ((test_mode == TEST_OFF) && out_inv && (enc_sel == ENC_OFFSET))
      |=> data_out_q == ~$past(conv_word))
      else $error("inverted output word wrong");

   chk_twos_encode: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (s_plain_path and (enc_sel == ENC_TWOS))
      |=> data_out_q == ($past(conv_word) ^ MSB_MASK))
      else $error("twos complement word wrong");

   chk_term_field: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_term_wr |=> term_sel == $past(wr_data[TERM_LSB +: 2]))
      else $error("termination select does not follow write");

   chk_phase_clamp: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_phase && (wr_data[PHASE_LSB +: 4] >= PHASE_CLAMP)) |=> clk_phase_sel == PHASE_CLAMP)
      else $error("phase code not clamped");

   chk_phase_free: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_phase and s_plain_path and (enc_sel == ENC_OFFSET) and !wr_fmt)
      |=> data_out_q == $past(conv_word))
      else $error("phase write disturbed data path");

   chk_pat_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_plo |=> user_pattern[7:0] == $past(wr_data))
      else $error("pattern low byte wrong");

   chk_pat_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_phi |=> user_pattern[PAT_W-1:8] == $past(wr_data))
      else $error("pattern high byte wrong");

   chk_user_test: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ((test_mode == TEST_USER) && !out_inv) |=> data_out_q == $past(user_pattern))
      else $error("user pattern not on output");

   chk_unused_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (rd_en && (reg_addr == ADDR_FMT)) |=> (rd_data_q & ~MASK_FMT) == 8'h00)
      else $error("unused format bits read nonzero");

   chk_phase_pass: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_phase && (wr_data[PHASE_LSB +: 4] < PHASE_CLAMP))
      |=> clk_phase_sel == $past(wr_data[PHASE_LSB +: 4]))
      else $error("phase code below clamp not passed through");

   chk_test_gen: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ((test_mode != TEST_OFF) && (test_mode != TEST_USER) && !out_inv)
      |=> data_out_q == $past(test_gen_data))
      else $error("generator test data not on output");

   chk_rd_unmapped: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (rd_en && !addr_mapped) |=> rd_data_q == 8'h00)
      else $error("unmapped address read not zero");

endmodule

/* dv/aoc_host_model.sv */
// Serial port host model that issues register writes and reads.
`timescale 1ns/10ps
module aoc_host_model
(
   input  wire logic       clk_sys,
   output logic            wr_en,
   output logic            rd_en,
   output logic      [7:0] reg_addr,
   output logic      [7:0] wr_data
);
   // Idle bus carries no stale value.
   initial
   begin
      wr_en = 1'b0;
      rd_en = 1'b0;
      reg_addr = 8'h5A;
      wr_data = 8'hA5;
   end

   // One-cycle write strobe; data is scrambled once released.
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      wr_en = 1'b1;
      reg_addr = a;
      wr_data = d;
      @(negedge clk_sys);
      wr_en = 1'b0;
      reg_addr = ~a;
      wr_data = ~d;
   endtask

   // One-cycle read strobe; read data is settled on return.
   task automatic read(input logic [7:0] a);
      @(negedge clk_sys);
      rd_en = 1'b1;
      reg_addr = a;
      @(negedge clk_sys);
      rd_en = 1'b0;
      reg_addr = ~a;
   endtask
endmodule

/* dv/testbench.sv */
// Self-checking bench for the output configuration register bank.
`timescale 1ns/10ps
module testbench;
   import aoc_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic        wr_en;
   logic        rd_en;
   logic [7:0]  reg_addr;
   logic [7:0]  wr_data;
   logic [7:0]  rd_data_q;
   logic [3:0]  test_mode = TEST_OFF;
   logic [15:0] test_gen_data = 16'hA5A5;
   logic [9:0]  conv_data = 10'h200;
   logic [15:0] data_out_q;
   logic        lvds_low_power;
   logic [1:0]  term_sel;
   logic [3:0]  clk_phase_sel;
   logic [15:0] user_pattern;
   int          n_errors = 0;
   int          samples_checked = 0;
   int          cyc = 0;

   // Clock at 100 MHz.
   always #5 clk_sys = ~clk_sys;

   aoc_host_model i_host (.clk_sys(clk_sys), .wr_en(wr_en), .rd_en(rd_en),
      .reg_addr(reg_addr), .wr_data(wr_data));
   aoc_output_config_regs i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .wr_en(wr_en),
      .rd_en(rd_en), .reg_addr(reg_addr), .wr_data(wr_data), .rd_data_q(rd_data_q),
      .test_mode(test_mode), .test_gen_data(test_gen_data), .conv_data(conv_data),
      .data_out_q(data_out_q), .lvds_low_power(lvds_low_power), .term_sel(term_sel),
      .clk_phase_sel(clk_phase_sel), .user_pattern(user_pattern));

   // Compares one result and counts a mismatch.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      i_host.read(a);
      chk({8'h00, rd_data_q}, {8'h00, e});
   endtask

   // Selects a format and test mode, then checks the next output word.
   task automatic dchk(input logic [3:0] tm, input logic [7:0] f, input logic [15:0] e);
      i_host.write(ADDR_FMT, f);
      test_mode = tm;
      @(negedge clk_sys);
      chk(data_out_q, e);
   endtask

   task automatic print_verdict;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Cuts a hung run short.
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_errors++;
         print_verdict();
      end
   end

   // Main sequence.
   initial
   begin
      repeat (20) @(negedge clk_sys);
      rst_n = 1'b1;
      rdchk(ADDR_FMT, 8'h00);
      rdchk(ADDR_TERM, 8'h00);
      rdchk(ADDR_PHASE, 8'h03);
      rdchk(ADDR_PLO, 8'h00);
      rdchk(ADDR_PHI, 8'h00);
      rdchk(8'h17, 8'h00);
      $display("test reset done");
      i_host.write(ADDR_FMT, 8'hFF);
      i_host.write(ADDR_TERM, 8'hFF);
      i_host.write(ADDR_PHI, 8'hFF);
      i_host.write(8'h17, 8'h00);
      rdchk(ADDR_FMT, 8'h47);
      rdchk(ADDR_TERM, 8'h30);
      chk({15'h0, lvds_low_power}, 16'h0001);
      chk({14'h0, term_sel}, 16'h0003);
      chk(user_pattern, 16'hFF00);
      $display("test masks done");
      for (int c = 0; c < 16; c++)
      begin
         i_host.write(ADDR_PHASE, 8'(c));
         chk({12'h0, clk_phase_sel}, 16'(c > 10 ? 11 : c));
      end
      rdchk(ADDR_PHASE, 8'h0F);
      $display("test phase done");
      i_host.write(ADDR_PLO, 8'h34);
      i_host.write(ADDR_PHI, 8'h12);
      chk(user_pattern, 16'h1234);
      dchk(TEST_OFF, 8'h00, 16'h0200);
      dchk(TEST_OFF, 8'h01, 16'h0000);
      dchk(TEST_OFF, 8'h05, 16'hFFFF);
      dchk(TEST_USER, 8'h00, 16'h1234);
      dchk(4'h1, 8'h04, 16'h5A5A);
      dchk(4'h2, 8'h00, 16'hA5A5);
      conv_data = 10'h155;
      dchk(TEST_OFF, 8'h01, 16'h0355);
      dchk(TEST_OFF, 8'h04, 16'hFEAA);
      dchk(TEST_OFF, 8'h03, 16'h0155);
      dchk(TEST_OFF, 8'h00, 16'h0155);
      i_host.write(ADDR_PHASE, 8'h0A);
      chk(data_out_q, 16'h0155);
      chk({12'h0, clk_phase_sel}, 16'h000A);
      $display("test data path done");
      print_verdict();
   end
endmodule
